// ---- design/hfp_port_top.sv ----
// host register and fifo port access layer of the ethernet controller
// assumes one-cycle read and write strobes, synchronous to CLK, never together
//
// Overview of operation
// - writes to read-only locations change nothing and cause no side effect
// - reads of write-only locations always return zero
// - write-one-clear bits clear on a written one, keep on zero
// - clear-on-read bits return their value, then clear from that read
// - latch high and latch low bits hold their capture until read
// - soft-reset-exempt fields keep their value across a software reset
// - reserved register reads may return anything; here zero
// - any reset loads defaults, except soft-reset-exempt fields on software reset
// - four fifos exposed; data and status sizes set by control register
// - receive status pop port returns oldest entry and removes it
// - receive status view port returns oldest entry, removes nothing
// - receive data fifo is read-only; every read consumes the word
// - whole receive data window aliases the same popping fifo port
// - transmit status pop port returns oldest entry and removes it
// - transmit status view port returns oldest entry, removes nothing
// - writes anywhere in transmit data window push the same fifo
`timescale 1ns/100ps
`default_nettype none

module hfp_port_top (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic [7:0] HOST_ADDR,
    input wire logic HOST_RD,
    input wire logic HOST_WR,
    input wire logic [31:0] HOST_WDATA,
    output var logic [31:0] HOST_RDATA,
    output var logic HOST_RVALID,
    input wire logic [31:0] RXD_DATA,
    input wire logic RXD_VALID,
    output var logic RXD_POP,
    input wire logic [31:0] RXS_DATA,
    input wire logic RXS_VALID,
    output var logic RXS_POP,
    input wire logic [31:0] TXS_DATA,
    input wire logic TXS_VALID,
    output var logic TXS_POP,
    output var logic [31:0] TXD_DATA,
    output var logic TXD_PUSH,
    input wire logic TXD_READY,
    input wire logic [3:0] STATUS_EVT,
    output var logic [15:0] FIFO_SIZE_CFG,
    output var logic [7:0] KEEP_CFG,
    output var logic [31:0] CMD_WORD,
    output var logic SOFT_RST
);

    // address decode
    logic [7:0] word_addr;
    logic [7:0] win_addr;
    logic in_rxd;
    logic in_txd;
    logic at_rxs_pop;
    logic at_rxs_view;
    logic at_txs_pop;
    logic at_txs_view;
    logic at_id;
    logic at_cfg;
    logic at_sts;
    logic at_cmd;

    assign word_addr = HOST_ADDR & hfp_pkg::HFP_WORD_MASK;
    assign win_addr = HOST_ADDR & hfp_pkg::HFP_WIN_MASK;
    assign in_rxd = (win_addr == hfp_pkg::HFP_RXD_WIN_BASE);
    assign in_txd = (win_addr == hfp_pkg::HFP_TXD_WIN_BASE);
    assign at_rxs_pop = (word_addr == hfp_pkg::HFP_RXS_POP_OFS);
    assign at_rxs_view = (word_addr == hfp_pkg::HFP_RXS_VIEW_OFS);
    assign at_txs_pop = (word_addr == hfp_pkg::HFP_TXS_POP_OFS);
    assign at_txs_view = (word_addr == hfp_pkg::HFP_TXS_VIEW_OFS);
    assign at_id = (word_addr == hfp_pkg::HFP_ID_OFS);
    assign at_cfg = (word_addr == hfp_pkg::HFP_CFG_OFS);
    assign at_sts = (word_addr == hfp_pkg::HFP_STS_OFS);
    assign at_cmd = (word_addr == hfp_pkg::HFP_CMD_OFS);

    // qualified strobes
    logic rd;
    logic wr;
    logic rd_sts;
    logic wr_sts;

    assign rd = CE && HOST_RD;
    assign wr = CE && HOST_WR;
    assign rd_sts = rd && at_sts;
    assign wr_sts = wr && at_sts;

    // fifo side effects, only the pop and push ports have them
    logic rxd_pop_d;
    logic rxs_pop_d;
    logic txs_pop_d;
    logic txd_push_d;
    logic txd_ovr;

    assign rxd_pop_d = rd && in_rxd && RXD_VALID;
    assign rxs_pop_d = rd && at_rxs_pop && RXS_VALID;
    assign txs_pop_d = rd && at_txs_pop && TXS_VALID;
    assign txd_push_d = wr && in_txd && TXD_READY;
    assign txd_ovr = wr && in_txd && !TXD_READY;

    // control state
    logic [15:0] size_q;
    logic [7:0] keep_q;
    logic [31:0] cmd_q;
    logic srst_q;
    logic srst_d;
    logic [15:0] size_d;
    logic [7:0] keep_d;
    logic [31:0] cmd_d;

    // register writes; read-only and window writes fall through untouched
    assign srst_d = wr && at_cfg && HOST_WDATA[hfp_pkg::HFP_CFG_SRST_BIT];
    assign size_d = (wr && at_cfg)
        ? HOST_WDATA[hfp_pkg::HFP_CFG_SIZE_LSB +: hfp_pkg::HFP_CFG_SIZE_W] : size_q;
    assign keep_d = (wr && at_cfg)
        ? HOST_WDATA[hfp_pkg::HFP_CFG_KEEP_LSB +: hfp_pkg::HFP_CFG_KEEP_W] : keep_q;
    assign cmd_d = (wr && at_cmd) ? HOST_WDATA : cmd_q;

    // self-clearing soft reset trigger, one cycle wide
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            srst_q <= 1'b0;
        end else if (CE) begin
            srst_q <= srst_d;
        end
    end

    // software-reset-affected fields
    always_ff @(posedge CLK) begin
        if (!RST_N || (CE && srst_q)) begin
            size_q <= hfp_pkg::HFP_CFG_SIZE_RST;
            cmd_q <= hfp_pkg::HFP_CMD_RST;
        end else if (CE) begin
            size_q <= size_d;
            cmd_q <= cmd_d;
        end
    end

    // exempt field, only the hard reset restores it
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            keep_q <= hfp_pkg::HFP_CFG_KEEP_RST;
        end else if (CE) begin
            keep_q <= keep_d;
        end
    end

    // status bits with their access attributes
    logic w1c_bit;
    logic cor_bit;
    logic lhi_bit;
    logic llo_bit;
    logic ovr_bit;

    // write-one-clear event flag
    hfp_status_bit #(.MODE(hfp_pkg::HFP_WRITE_ONE_CLEAR_ATTR)) u_w1c (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .soft_rst(srst_q),
        .evt(STATUS_EVT[0]),
        .wr_clr(wr_sts && HOST_WDATA[hfp_pkg::HFP_STS_W1C_BIT]),
        .rd_clr(1'b0),
        .q(w1c_bit)
    );

    // clear-on-read event flag
    hfp_status_bit #(.MODE(hfp_pkg::HFP_CLEAR_ON_READ_ATTR)) u_cor (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .soft_rst(srst_q),
        .evt(STATUS_EVT[1]),
        .wr_clr(1'b0),
        .rd_clr(rd_sts),
        .q(cor_bit)
    );

    // latch of a high condition
    hfp_status_bit #(.MODE(hfp_pkg::HFP_LATCH_HIGH_ATTR)) u_lhi (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .soft_rst(srst_q),
        .evt(STATUS_EVT[2]),
        .wr_clr(1'b0),
        .rd_clr(rd_sts),
        .q(lhi_bit)
    );

    // latch of a low condition
    hfp_status_bit #(.MODE(hfp_pkg::HFP_LATCH_LOW_ATTR)) u_llo (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .soft_rst(srst_q),
        .evt(STATUS_EVT[3]),
        .wr_clr(1'b0),
        .rd_clr(rd_sts),
        .q(llo_bit)
    );

    // transmit push dropped while the fifo refused it
    hfp_status_bit #(.MODE(hfp_pkg::HFP_WRITE_ONE_CLEAR_ATTR)) u_ovr (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .soft_rst(srst_q),
        .evt(txd_ovr),
        .wr_clr(wr_sts && HOST_WDATA[hfp_pkg::HFP_STS_OVR_BIT]),
        .rd_clr(1'b0),
        .q(ovr_bit)
    );

    // status word seen by the host
    logic [31:0] sts_word;

    always_comb begin
        sts_word = hfp_pkg::HFP_ZERO_WORD;
        sts_word[hfp_pkg::HFP_STS_W1C_BIT] = w1c_bit;
        sts_word[hfp_pkg::HFP_STS_COR_BIT] = cor_bit;
        sts_word[hfp_pkg::HFP_STS_LHI_BIT] = lhi_bit;
        sts_word[hfp_pkg::HFP_STS_LLO_BIT] = llo_bit;
        sts_word[hfp_pkg::HFP_STS_OVR_BIT] = ovr_bit;
        sts_word[hfp_pkg::HFP_STS_RXD_BIT] = RXD_VALID;
        sts_word[hfp_pkg::HFP_STS_RXS_BIT] = RXS_VALID;
        sts_word[hfp_pkg::HFP_STS_TXS_BIT] = TXS_VALID;
        sts_word[hfp_pkg::HFP_STS_TXD_BIT] = TXD_READY;
    end

    // config word seen by the host
    logic [31:0] cfg_word;

    always_comb begin
        cfg_word = hfp_pkg::HFP_ZERO_WORD;
        cfg_word[hfp_pkg::HFP_CFG_SIZE_LSB +: hfp_pkg::HFP_CFG_SIZE_W] = size_q;
        cfg_word[hfp_pkg::HFP_CFG_KEEP_LSB +: hfp_pkg::HFP_CFG_KEEP_W] = keep_q;
        cfg_word[hfp_pkg::HFP_CFG_SRST_BIT] = srst_q;
    end

    // read data select; empty fifos and unmapped words read as zero
    logic [31:0] rxd_word;
    logic [31:0] rxs_word;
    logic [31:0] txs_word;
    logic [31:0] rd_word;

    assign rxd_word = RXD_VALID ? RXD_DATA : hfp_pkg::HFP_ZERO_WORD;
    assign rxs_word = RXS_VALID ? RXS_DATA : hfp_pkg::HFP_ZERO_WORD;
    assign txs_word = TXS_VALID ? TXS_DATA : hfp_pkg::HFP_ZERO_WORD;
    assign rd_word = in_rxd ? rxd_word :
        (at_rxs_pop || at_rxs_view) ? rxs_word :
        (at_txs_pop || at_txs_view) ? txs_word :
        at_id ? hfp_pkg::HFP_ID_VALUE :
        at_cfg ? cfg_word :
        at_sts ? sts_word :
        hfp_pkg::HFP_ZERO_WORD;

    // registered host answer and fifo strobes
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            HOST_RDATA <= hfp_pkg::HFP_ZERO_WORD;
            HOST_RVALID <= 1'b0;
            RXD_POP <= 1'b0;
            RXS_POP <= 1'b0;
            TXS_POP <= 1'b0;
            TXD_PUSH <= 1'b0;
            TXD_DATA <= hfp_pkg::HFP_ZERO_WORD;
        end else if (CE) begin
            HOST_RDATA <= HOST_RD ? rd_word : hfp_pkg::HFP_ZERO_WORD;
            HOST_RVALID <= HOST_RD;
            RXD_POP <= rxd_pop_d;
            RXS_POP <= rxs_pop_d;
            TXS_POP <= txs_pop_d;
            TXD_PUSH <= txd_push_d;
            TXD_DATA <= txd_push_d ? HOST_WDATA : TXD_DATA;
        end
    end

    // configuration outputs straight from their registers
    assign FIFO_SIZE_CFG = size_q;
    assign KEEP_CFG = keep_q;
    assign CMD_WORD = cmd_q;
    assign SOFT_RST = srst_q;

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    chk_ro_write_inert: assert property (
        wr && (at_id || at_sts) && !srst_q |=> !RXD_POP && !RXS_POP && !TXS_POP
            && !TXD_PUSH && $stable(size_q) && $stable(cmd_q))
        else $error("write to read-only location had an effect");

    chk_wo_reads_zero: assert property (
        rd && (at_cmd || in_txd) |=> HOST_RVALID && (HOST_RDATA == 32'h0000_0000))
        else $error("write-only location read back nonzero");

    chk_w1c_clears: assert property (
        wr_sts && HOST_WDATA[hfp_pkg::HFP_STS_W1C_BIT] && !STATUS_EVT[0] && !srst_q
            |=> !w1c_bit)
        else $error("write one did not clear the flag");

    chk_w1c_zero_keeps: assert property (
        wr_sts && !HOST_WDATA[hfp_pkg::HFP_STS_W1C_BIT] && w1c_bit && !srst_q |=> w1c_bit)
        else $error("write zero disturbed the flag");

    chk_cor_read_clear: assert property (
        rd_sts && cor_bit && !STATUS_EVT[1] && !srst_q
            |=> !cor_bit && HOST_RDATA[hfp_pkg::HFP_STS_COR_BIT])
        else $error("clear-on-read flag not returned then cleared");

    chk_lhi_holds: assert property (
        CE && lhi_bit && !rd_sts && !srst_q |=> lhi_bit)
        else $error("latched high bit lost before read");

    chk_exempt_kept: assert property (
        CE && srst_q && !(wr && at_cfg) |=> $stable(keep_q))
        else $error("exempt field changed by software reset");

    chk_soft_defaults: assert property (
        CE && srst_q |=> size_q == hfp_pkg::HFP_CFG_SIZE_RST && cmd_q == hfp_pkg::HFP_CMD_RST
            && !w1c_bit && !cor_bit)
        else $error("software reset left non-default state");

    chk_rxs_pop_word: assert property (
        rd && at_rxs_pop && RXS_VALID |=> RXS_POP && HOST_RDATA == $past(RXS_DATA))
        else $error("status pop did not return and remove the entry");

    chk_view_no_pop: assert property (
        rd && (at_rxs_view || at_txs_view) |=> !RXS_POP && !TXS_POP)
        else $error("view port removed an entry");

    chk_rxd_alias_pop: assert property (
        rd && in_rxd && RXD_VALID |=> RXD_POP && HOST_RDATA == $past(RXD_DATA)
            ##1 (!RXD_POP || $past(rd && in_rxd && RXD_VALID)))
        else $error("receive window read did not pop exactly once");

    chk_txd_alias_push: assert property (
        wr && in_txd && TXD_READY |=> TXD_PUSH && TXD_DATA == $past(HOST_WDATA))
        else $error("transmit window write did not push");

    chk_rxd_write_ignored: assert property (
        wr && in_rxd |=> !RXD_POP && !TXD_PUSH)
        else $error("write to receive window had an effect");

    cov_rxd_pop: cover property (rd && in_rxd && RXD_VALID ##1 RXD_POP);
    cov_txd_push: cover property (wr && in_txd && TXD_READY ##1 TXD_PUSH);
    cov_soft_reset: cover property (srst_q && CE ##1 !srst_q);
    cov_cor_clear: cover property (rd_sts && cor_bit ##1 !cor_bit);

endmodule // hfp_port_top

`default_nettype wire

// ---- shared/hfp_pkg.sv ----
// shared constants of the host fifo port access layer
// assumes byte addressing on the host bus, one aligned word per register
`default_nettype none

package hfp_pkg;

    // kinds of status bit handled by the attribute cell
    typedef enum logic [1:0] {
        HFP_WRITE_ONE_CLEAR_ATTR,
        HFP_CLEAR_ON_READ_ATTR,
        HFP_LATCH_HIGH_ATTR,
        HFP_LATCH_LOW_ATTR
    } hfp_bit_mode_t;

    localparam int unsigned HFP_AW = 8;
    localparam int unsigned HFP_DW = 32;
    localparam int unsigned HFP_NEVT = 4;

    // aliased data windows: compare after masking the alias bits
    localparam logic [7:0] HFP_WIN_MASK = 8'he0;
    localparam logic [7:0] HFP_RXD_WIN_BASE = 8'h00;
    localparam logic [7:0] HFP_TXD_WIN_BASE = 8'h20;

    // single word locations, compared on the word address bits
    localparam logic [7:0] HFP_WORD_MASK = 8'hfc;
    localparam logic [7:0] HFP_RXS_POP_OFS = 8'h40;
    localparam logic [7:0] HFP_RXS_VIEW_OFS = 8'h44;
    localparam logic [7:0] HFP_TXS_POP_OFS = 8'h48;
    localparam logic [7:0] HFP_TXS_VIEW_OFS = 8'h4c;
    localparam logic [7:0] HFP_ID_OFS = 8'h50;
    localparam logic [7:0] HFP_CFG_OFS = 8'h54;
    localparam logic [7:0] HFP_STS_OFS = 8'h58;
    localparam logic [7:0] HFP_CMD_OFS = 8'h5c;

    // identity word, value is arbitrary
    localparam logic [31:0] HFP_ID_VALUE = 32'h00a5_0001;

    // config register layout
    localparam int unsigned HFP_CFG_SIZE_LSB = 0;
    localparam int unsigned HFP_CFG_SIZE_W = 16;
    localparam int unsigned HFP_CFG_KEEP_LSB = 16;
    localparam int unsigned HFP_CFG_KEEP_W = 8;
    localparam int unsigned HFP_CFG_SRST_BIT = 31;
    localparam logic [15:0] HFP_CFG_SIZE_RST = 16'h0000;
    localparam logic [7:0] HFP_CFG_KEEP_RST = 8'h00;

    // status register layout
    localparam int unsigned HFP_STS_W1C_BIT = 0;
    localparam int unsigned HFP_STS_COR_BIT = 1;
    localparam int unsigned HFP_STS_LHI_BIT = 2;
    localparam int unsigned HFP_STS_LLO_BIT = 3;
    localparam int unsigned HFP_STS_OVR_BIT = 4;
    localparam int unsigned HFP_STS_RXD_BIT = 8;
    localparam int unsigned HFP_STS_RXS_BIT = 9;
    localparam int unsigned HFP_STS_TXS_BIT = 10;
    localparam int unsigned HFP_STS_TXD_BIT = 11;

    localparam logic [31:0] HFP_CMD_RST = 32'h0000_0000;
    localparam logic [31:0] HFP_ZERO_WORD = 32'h0000_0000;

endpackage

`default_nettype wire

// ---- design/hfp_status_bit.sv ----
// one status bit with a selectable access attribute
// assumes clear strobes are single cycle and qualified by the caller
`timescale 1ns/100ps
`default_nettype none

module hfp_status_bit #(
    parameter hfp_pkg::hfp_bit_mode_t MODE = hfp_pkg::HFP_WRITE_ONE_CLEAR_ATTR
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic soft_rst,
    input wire logic evt,
    input wire logic wr_clr,
    input wire logic rd_clr,
    output var logic q
);

    localparam bit IS_LOW = (MODE == hfp_pkg::HFP_LATCH_LOW_ATTR);
    localparam logic RST_VAL = IS_LOW ? 1'b1 : 1'b0;

    logic bit_q;
    logic bit_d;
    logic clr;

    // which strobe clears this kind of bit
    assign clr = (MODE == hfp_pkg::HFP_WRITE_ONE_CLEAR_ATTR) ? wr_clr : rd_clr;

    // set wins over clear; latch low holds a seen low until read
    assign bit_d = IS_LOW ? (clr ? evt : (bit_q & evt)) : ((bit_q & ~clr) | evt);

    // state update, frozen while ce is low
    always_ff @(posedge clk) begin
        if (!rst_n || (ce && soft_rst)) begin
            bit_q <= RST_VAL;
        end else if (ce) begin
            bit_q <= bit_d;
        end
    end

    assign q = bit_q;

endmodule // hfp_status_bit

`default_nettype wire

// ---- testbench/hfp_fifo_model.sv ----
// behavioural model of the rx and tx fifos behind the host port
// assumes pop and push are one-cycle pulses, sampled on the rising clock
`timescale 1ns/100ps
`default_nettype none

module hfp_fifo_model (
    input wire logic clk,
    input wire logic rxd_pop,
    input wire logic rxs_pop,
    input wire logic txs_pop,
    input wire logic txd_push,
    input wire logic [31:0] txd_data,
    output logic [31:0] rxd_data,
    output logic rxd_valid,
    output logic [31:0] rxs_data,
    output logic rxs_valid,
    output logic [31:0] txs_data,
    output logic txs_valid,
    output logic txd_ready
);
    logic [31:0] rxd_q[$];
    logic [31:0] rxs_q[$];
    logic [31:0] txs_q[$];
    logic [31:0] txd_got[$];
    logic [31:0] rxd_last = 32'h0000_0000;
    logic [31:0] rxs_last = 32'h0000_0000;
    logic [31:0] txs_last = 32'h0000_0000;
    logic ready_en = 1'b1;

    // heads; an empty fifo shows the inverse of its last word, never a stale match
    task automatic refresh();
        rxd_valid <= (rxd_q.size() != 0);
        rxd_data <= (rxd_q.size() != 0) ? rxd_q[0] : ~rxd_last;
        rxs_valid <= (rxs_q.size() != 0);
        rxs_data <= (rxs_q.size() != 0) ? rxs_q[0] : ~rxs_last;
        txs_valid <= (txs_q.size() != 0);
        txs_data <= (txs_q.size() != 0) ? txs_q[0] : ~txs_last;
        txd_ready <= ready_en;
    endtask

    // preload one word: 0 rx data, 1 rx status, else tx status
    task automatic load(input int which, input logic [31:0] w);
        if (which == 0) begin
            rxd_q.push_back(w);
        end else if (which == 1) begin
            rxs_q.push_back(w);
        end else begin
            txs_q.push_back(w);
        end
        refresh();
    endtask

    initial begin
        refresh();
    end

    // pops and pushes land on the edge after the strobe
    always @(posedge clk) begin
        if (rxd_pop && rxd_q.size() != 0) rxd_last = rxd_q.pop_front();
        if (rxs_pop && rxs_q.size() != 0) rxs_last = rxs_q.pop_front();
        if (txs_pop && txs_q.size() != 0) txs_last = txs_q.pop_front();
        if (txd_push) txd_got.push_back(txd_data);
        refresh();
    end
endmodule // hfp_fifo_model

`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench of the host register and fifo port layer
// assumes the fifo model file; inputs driven on the falling clock edge
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    logic clk, rst_n, ce, host_rd, host_wr, host_rvalid, srst_seen;
    logic rxd_pop, rxs_pop, txs_pop, txd_push, soft_rst;
    logic rxd_valid, rxs_valid, txs_valid, txd_ready;
    logic [7:0] host_addr, keep_cfg;
    logic [3:0] status_evt;
    logic [15:0] fifo_size_cfg;
    logic [31:0] host_wdata, host_rdata, rxd_data, rxs_data, txs_data, txd_data, cmd_word;
    int miscompares = 0;
    int checks_done = 0;

    hfp_port_top dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .HOST_ADDR(host_addr),
        .HOST_RD(host_rd), .HOST_WR(host_wr), .HOST_WDATA(host_wdata),
        .HOST_RDATA(host_rdata), .HOST_RVALID(host_rvalid), .RXD_DATA(rxd_data),
        .RXD_VALID(rxd_valid), .RXD_POP(rxd_pop), .RXS_DATA(rxs_data),
        .RXS_VALID(rxs_valid), .RXS_POP(rxs_pop), .TXS_DATA(txs_data),
        .TXS_VALID(txs_valid), .TXS_POP(txs_pop), .TXD_DATA(txd_data),
        .TXD_PUSH(txd_push), .TXD_READY(txd_ready), .STATUS_EVT(status_evt),
        .FIFO_SIZE_CFG(fifo_size_cfg), .KEEP_CFG(keep_cfg), .CMD_WORD(cmd_word),
        .SOFT_RST(soft_rst));

    hfp_fifo_model fifo (.clk(clk), .rxd_pop(rxd_pop), .rxs_pop(rxs_pop),
        .txs_pop(txs_pop), .txd_push(txd_push), .txd_data(txd_data),
        .rxd_data(rxd_data), .rxd_valid(rxd_valid), .rxs_data(rxs_data),
        .rxs_valid(rxs_valid), .txs_data(txs_data), .txs_valid(txs_valid),
        .txd_ready(txd_ready));

    // 200 mhz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // sticky record of the software reset pulse
    always @(posedge clk) begin
        if (soft_rst === 1'b1) srst_seen <= 1'b1;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one read; idle cycle after so a pop lands before the next request
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        int n;
        @(negedge clk);
        host_addr = a;
        host_rd = 1'b1;
        @(negedge clk);
        host_rd = 1'b0;
        n = 0;
        while (host_rvalid !== 1'b1) begin
            n++;
            if (n > 4) begin
                miscompares++;
                results();
            end
            @(negedge clk);
        end
        chk(host_rdata, exp);
        @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(negedge clk);
        host_addr = a;
        host_wdata = w;
        host_wr = 1'b1;
        @(negedge clk);
        host_wr = 1'b0;
        @(negedge clk);
    endtask

    // defaults, read-only id, write-only command word
    task automatic t_defaults();
        rd_chk(hfp_pkg::HFP_CFG_OFS, 32'h0000_0000);
        rd_chk(hfp_pkg::HFP_STS_OFS, 32'h0000_0808);
        wr(hfp_pkg::HFP_ID_OFS, 32'hffff_ffff);
        rd_chk(hfp_pkg::HFP_ID_OFS, hfp_pkg::HFP_ID_VALUE);
        wr(hfp_pkg::HFP_CMD_OFS, 32'h0000_1234);
        chk(cmd_word, 32'h0000_1234);
        rd_chk(hfp_pkg::HFP_CMD_OFS, 32'h0000_0000);
        rd_chk(8'h60, 32'h0000_0000);
    endtask

    // write-one-clear, clear-on-read, latch high and latch low flags
    task automatic t_status();
        @(negedge clk);
        status_evt = 4'b0111;
        @(negedge clk);
        status_evt = 4'b1000;
        rd_chk(hfp_pkg::HFP_STS_OFS, 32'h0000_0807);
        rd_chk(hfp_pkg::HFP_STS_OFS, 32'h0000_0809);
        wr(hfp_pkg::HFP_STS_OFS, 32'h0000_0000);
        rd_chk(hfp_pkg::HFP_STS_OFS, 32'h0000_0809);
        wr(hfp_pkg::HFP_STS_OFS, 32'h0000_0001);
        rd_chk(hfp_pkg::HFP_STS_OFS, 32'h0000_0808);
    endtask

    // software reset keeps the exempt field, restores the rest
    task automatic t_soft_reset();
        wr(hfp_pkg::HFP_CFG_OFS, 32'h005a_0040);
        chk({16'h0000, fifo_size_cfg}, 32'h0000_0040);
        rd_chk(hfp_pkg::HFP_CFG_OFS, 32'h005a_0040);
        @(negedge clk);
        status_evt = 4'b0001;
        @(negedge clk);
        status_evt = 4'b1000;
        srst_seen = 1'b0;
        wr(hfp_pkg::HFP_CFG_OFS, 32'h805a_0077);
        @(negedge clk);
        chk({31'h0, srst_seen}, 32'h0000_0001);
        chk({24'h0, keep_cfg}, 32'h0000_005a);
        chk(cmd_word, hfp_pkg::HFP_CMD_RST);
        rd_chk(hfp_pkg::HFP_CFG_OFS, 32'h005a_0000);
        rd_chk(hfp_pkg::HFP_STS_OFS, 32'h0000_0808);
    endtask

    // rx data window aliases one popping port; writes there are ignored
    task automatic t_rx_data();
        fifo.load(0, 32'h1111_1111);
        fifo.load(0, 32'h2222_2222);
        fifo.load(0, 32'h3333_3333);
        wr(8'h04, 32'hffff_ffff);
        rd_chk(8'h00, 32'h1111_1111);
        rd_chk(8'h1c, 32'h2222_2222);
        rd_chk(8'h0c, 32'h3333_3333);
        rd_chk(8'h10, 32'h0000_0000);
        chk(fifo.rxd_q.size(), 32'h0000_0000);
    endtask

    // status fifos: view leaves the head, pop removes it; rx then tx
    task automatic t_status_fifos();
        logic [7:0] base;
        for (int k = 0; k < 2; k++) begin
            base = (k == 0) ? hfp_pkg::HFP_RXS_POP_OFS : hfp_pkg::HFP_TXS_POP_OFS;
            fifo.load(k + 1, 32'ha000_0001 + k);
            fifo.load(k + 1, 32'hb000_0002 + k);
            rd_chk(base + 8'h04, 32'ha000_0001 + k);
            rd_chk(base + 8'h04, 32'ha000_0001 + k);
            rd_chk(base, 32'ha000_0001 + k);
            rd_chk(base + 8'h04, 32'hb000_0002 + k);
            rd_chk(base, 32'hb000_0002 + k);
            rd_chk(base, 32'h0000_0000);
        end
    endtask

    // tx data window pushes from any alias; reads give zero; full fifo drops
    task automatic t_tx_data();
        wr(8'h20, 32'hc0de_0001);
        wr(8'h3c, 32'hc0de_0002);
        wr(8'h28, 32'hc0de_0003);
        chk(txd_data, 32'hc0de_0003);
        rd_chk(8'h24, 32'h0000_0000);
        chk(fifo.txd_got.size(), 32'h0000_0003);
        chk(fifo.txd_got[0], 32'hc0de_0001);
        chk(fifo.txd_got[1], 32'hc0de_0002);
        @(negedge clk);
        fifo.ready_en = 1'b0;
        fifo.refresh();
        wr(8'h30, 32'hc0de_0004);
        chk(fifo.txd_got.size(), 32'h0000_0003);
        rd_chk(hfp_pkg::HFP_STS_OFS, 32'h0000_0018);
        fifo.ready_en = 1'b1;
        fifo.refresh();
        wr(hfp_pkg::HFP_STS_OFS, 32'h0000_0010);
        rd_chk(hfp_pkg::HFP_STS_OFS, 32'h0000_0808);
    endtask

    // ce low freezes state: a write and an event in that cycle are both lost
    task automatic t_clock_hold();
        @(negedge clk);
        ce = 1'b0;
        status_evt = 4'b1001;
        host_addr = hfp_pkg::HFP_CMD_OFS;
        host_wdata = 32'h0000_00ff;
        host_wr = 1'b1;
        @(negedge clk);
        ce = 1'b1;
        host_wr = 1'b0;
        status_evt = 4'b1000;
        chk(cmd_word, hfp_pkg::HFP_CMD_RST);
        rd_chk(hfp_pkg::HFP_STS_OFS, 32'h0000_0808);
    endtask

    // main sequence; reserved addresses are only ever read
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        host_rd = 1'b0;
        host_wr = 1'b0;
        host_addr = 8'h00;
        host_wdata = 32'h0000_0000;
        status_evt = 4'b1000;
        srst_seen = 1'b0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_defaults();
        t_status();
        t_soft_reset();
        t_rx_data();
        t_status_fifos();
        t_tx_data();
        t_clock_hold();
        results();
    end
endmodule // tb_top

`default_nettype wire
